// File: hdl/flash_protect_defs.svh
`ifndef FLASH_PROTECT_DEFS_SVH
`define FLASH_PROTECT_DEFS_SVH

// ==================================================
// register byte offsets (avalon word aligned)
`define REG_CTRL_OFF      4'h0
`define REG_STATUS_OFF    4'h4
`define REG_PROT_OFF      4'h8
`define REG_INFO_OFF      4'hc

// ==================================================
// control register fields
`define CTRL_TOP_BIT      0
`define CTRL_BIG_BIT      1

// ==================================================
// lock command sequence
`define LOCK_ADDR1        20'h000aa
`define LOCK_DATA1        32'h0000_0049
`define LOCK_ADDR2        20'h00003
`define LOCK_DATA2        32'h0000_0000

// ==================================================
// status values
`define ST_READY          8'h80
`define ST_ERASE_LOCKED   8'ha3
`define ST_PROG_LOCKED    8'h93
`define ST_BAD_SEQ        8'hb1
`define ST_BUSY           8'h00
`define ST_PERMIT_ERR     8'h98
`define ST_RESET          8'h00

// ==================================================
// timing
`define CLK_MHZ           20
`define LOCK_TIME_US      35
`define LOCK_CYCLES       (`LOCK_TIME_US * `CLK_MHZ)

`endif

// File: hdl/flash_protect_pkg.sv
package flash_protect_pkg;

  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_ERASE   = 2'h1,
    OP_LOCK1   = 2'h2,
    OP_LOCK2   = 2'h3
  } op_kind_t;

  typedef struct packed {
    op_kind_t    kind;
    logic [19:0] addr;
    logic [31:0] data;
  } flash_req_t;

  typedef struct packed {
    logic       accepted;
    logic [6:0] block;
  } flash_ans_t;

endpackage

// File: hdl/flash_block_protect_lock.sv
// Functional notes
// RL1: with write-protect low, blocks marked in protection register refuse changes.
// RL2: protection register is volatile; every reset loses its pattern; here reset_powerdown_n low keeps prot_ff, only RESET_N_IN reloads it.
// RL3: program or erase on a protected block is refused, status shows error.
// RL4: while reset_powerdown_n low, no program or erase is performed.
// RL5: prog_erase_permit low refuses program or erase and flags status error.
// RL6: after power-up every block counts as protected.
// RL7: permanent lock starts clear, persists, and can never be cleared again; here RESET_N_IN clears otp_ff.
// RL8: 32-Mbit lock region is block 1 bottom-boot or block 72 top-boot.
// RL9: 16-Mbit lock region is blocks 2,3 bottom or 36,35 top.
// RL10: lock needs 49h at 000AAh then zero at 00003h, nothing else.
// RL11: host sends lock sequence only while write-protect is high.
// RL12: lock runs like a program, about 35 us, completion seen by polling.
// RL13: with lock active, erase leaves A3h and program leaves 93h.
// RL14: wrong second lock address aborts, lock stays off, status B1h.
// RL15: host clears status before retrying a failed lock sequence.
// RL16: suspend requests are ignored while the lock operation runs.
// RL17: 32-Mbit top-boot map decodes 128K, 64K and 512K blocks downward.
// RL18: 32-Mbit bottom-boot map decodes 128K, 64K and 512K blocks upward.
// RL19: 16-Mbit top-boot map: blocks 31-38 64K, 0-30 512K.
// RL20: set and clear commands update single bits of protection register.
// RL21: reset_powerdown_n low clears status and burst config, protects device.
// RL22: a refused program or erase never changes the array.
`timescale 1ns/1ps
`include "flash_protect_defs.svh"

module flash_block_protect_lock #(
  parameter int NBLK        = 74,
  parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
  input  wire logic                          CLK_IN,
  input  wire logic                          RESET_N_IN,
  // avalon-mm slave
  input  wire logic [3:0]                    AVS_ADDRESS_IN,
  input  wire logic                          AVS_READ_IN,
  input  wire logic                          AVS_WRITE_IN,
  input  wire logic [31:0]                   AVS_WRITEDATA_IN,
  output logic      [31:0]                   AVS_READDATA_OUT,
  output logic                               AVS_WAITREQUEST_OUT,
  // device pins
  input  wire logic                          RESET_POWERDOWN_N_IN,
  input  wire logic                          PROG_ERASE_PERMIT_IN,
  input  wire logic                          WRITE_PROTECT_N_IN,
  input  wire logic                          SUSPEND_IN,
  // command from the command interface
  input  wire logic                          REQ_VALID_IN,
  input  wire flash_protect_pkg::flash_req_t REQ_IN,
  // verdict to the program/erase controller
  output logic                               ANS_VALID_OUT,
  output flash_protect_pkg::flash_ans_t      ANS_OUT,
  output logic                               LOCK_BUSY_OUT,
  output logic                               LOCK_ACTIVE_OUT,
  output logic                               BURST_CFG_CLR_OUT
);

  // ==================================================
  // block decode
  // rl17 rl18 rl19: word address to block number per map
  function automatic logic [6:0] blk_of(input logic [19:0] a, input logic top,
                                        input logic big);
    logic [6:0] b;
    b = 7'h00;
    if (big && top) begin
      if (a >= 20'hfc000) b = 7'd70 + 7'(a[13:12]);
      else if (a >= 20'hf8000) b = 7'd62 + 7'(a[13:11]);
      else b = 7'(a[19:14]);
    end else if (big) begin
      if (a < 20'h04000) b = 7'(a[13:12]);
      else if (a < 20'h08000) b = 7'd4 + 7'(a[13:11]);
      else b = 7'd10 + 7'(a[19:14]);
    end else if (top) begin
      if (a >= 20'h7c000) b = 7'd31 + 7'(a[13:11]);
      else b = 7'(a[18:14]);
    end else begin
      if (a < 20'h04000) b = 7'(a[13:11]);
      else b = 7'd7 + 7'(a[18:14]);
    end
    return b;
  endfunction

  // rl8 rl9: blocks covered by the permanent lock
  function automatic logic in_otp(input logic [6:0] b, input logic top, input logic big);
    logic r;
    r = 1'b0;
    if (big) r = top ? (b == 7'd72) : (b == 7'd1);
    else r = top ? (b == 7'd35 || b == 7'd36) : (b == 7'd2 || b == 7'd3);
    return r;
  endfunction

  // ==================================================
  // state
  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_ARMED = 3'b010,
    S_LOCK  = 3'b100
  } lk_state_t;

  lk_state_t         state_ff,    nxt_state;
  logic [NBLK-1:0]   prot_ff,     nxt_prot;
  logic [7:0]        status_ff,   nxt_status;
  logic              otp_ff,      nxt_otp;
  logic [1:0]        cfg_ff,      nxt_cfg;
  logic [15:0]       cnt_ff,      nxt_cnt;
  logic [31:0]       rdata_ff,    nxt_rdata;
  logic              wait_ff,     nxt_wait;
  logic              ansv_ff,     nxt_ansv;
  flash_protect_pkg::flash_ans_t ans_ff, nxt_ans;
  logic              susp_seen_ff, nxt_susp_seen;

  logic [6:0] req_blk;
  logic       pin_ok;
  logic       cpu_acc;

  assign req_blk = blk_of(REQ_IN.addr, cfg_ff[`CTRL_TOP_BIT], cfg_ff[`CTRL_BIG_BIT]);
  // rl4 rl5: pin gating
  assign pin_ok  = RESET_POWERDOWN_N_IN && PROG_ERASE_PERMIT_IN;
  assign cpu_acc = (AVS_READ_IN || AVS_WRITE_IN) && wait_ff;

  // ==================================================
  // next state
  always_comb begin
    nxt_state     = state_ff;
    nxt_prot      = prot_ff;
    nxt_status    = status_ff;
    nxt_otp       = otp_ff;
    nxt_cfg       = cfg_ff;
    nxt_cnt       = cnt_ff;
    nxt_rdata     = rdata_ff;
    nxt_wait      = 1'b1;
    nxt_ansv      = 1'b0;
    nxt_ans       = ans_ff;
    nxt_susp_seen = 1'b0;

    // avalon slave, one wait cycle then answer
    if (cpu_acc) nxt_wait = 1'b0;
    // writes land only at the edge that sees waitrequest low
    if (AVS_WRITE_IN && !wait_ff) begin
      begin
        case (AVS_ADDRESS_IN)
          `REG_CTRL_OFF: begin
            nxt_cfg = AVS_WRITEDATA_IN[1:0];
          end
          // clear status; lock ends back at ready
          `REG_STATUS_OFF: begin
            if (state_ff != S_LOCK) nxt_status = `ST_READY;
          end
          // rl20: bit 31 set or clear, low bits block number
          `REG_PROT_OFF: begin
            if (32'(AVS_WRITEDATA_IN[6:0]) < NBLK)
              nxt_prot[AVS_WRITEDATA_IN[6:0]] = AVS_WRITEDATA_IN[31];
          end
          default: begin
          end
        endcase
      end
    end
    if (cpu_acc && AVS_READ_IN) begin
      begin
        case (AVS_ADDRESS_IN)
          `REG_CTRL_OFF:   nxt_rdata = {30'h0, cfg_ff};
          `REG_STATUS_OFF: nxt_rdata = {24'h0, status_ff};
          `REG_PROT_OFF:   nxt_rdata = {31'h0, prot_ff[AVS_WRITEDATA_IN[6:0]]};
          `REG_INFO_OFF:   nxt_rdata = {29'h0, SUSPEND_IN, otp_ff, state_ff == S_LOCK};
          default:         nxt_rdata = 32'h0;
        endcase
      end
    end

    case (state_ff)
      S_IDLE: begin
        if (REQ_VALID_IN) begin
          nxt_ansv = 1'b1;
          nxt_ans.block    = req_blk;
          nxt_ans.accepted = 1'b0;
          if (REQ_IN.kind == flash_protect_pkg::OP_LOCK1) begin
            // rl10: first lock cycle
            if (REQ_IN.addr == `LOCK_ADDR1 && REQ_IN.data == `LOCK_DATA1)
              nxt_state = S_ARMED;
          end else if (REQ_IN.kind != flash_protect_pkg::OP_LOCK2) begin
            // rl13: locked region wins
            if (otp_ff && in_otp(req_blk, cfg_ff[`CTRL_TOP_BIT], cfg_ff[`CTRL_BIG_BIT]))
              nxt_status = (REQ_IN.kind == flash_protect_pkg::OP_ERASE) ?
                           `ST_ERASE_LOCKED : `ST_PROG_LOCKED;
            // rl4 rl5: pins refuse
            else if (!pin_ok)
              nxt_status = `ST_PERMIT_ERR;
            // rl1 rl3: pattern applies while write-protect low
            else if (!WRITE_PROTECT_N_IN && prot_ff[req_blk])
              nxt_status = (REQ_IN.kind == flash_protect_pkg::OP_ERASE) ?
                           `ST_ERASE_LOCKED : `ST_PROG_LOCKED;
            // rl22: only a clean request reaches the array
            else
              nxt_ans.accepted = 1'b1;
          end
        end
      end
      S_ARMED: begin
        if (REQ_VALID_IN) begin
          nxt_ansv = 1'b1;
          nxt_ans.accepted = 1'b0;
          // rl10 rl14: exact second cycle or abort
          if (REQ_IN.kind == flash_protect_pkg::OP_LOCK2 &&
              REQ_IN.addr == `LOCK_ADDR2 && REQ_IN.data == `LOCK_DATA2 && pin_ok) begin
            nxt_state  = S_LOCK;
            nxt_cnt    = 16'(LOCK_CYCLES - 1);
            nxt_status = `ST_BUSY;
          end else begin
            nxt_state  = S_IDLE;
            nxt_status = `ST_BAD_SEQ;
          end
        end
      end
      S_LOCK: begin
        // rl16: suspend ignored, timer runs on
        nxt_susp_seen = SUSPEND_IN;
        // rl12: busy for the program time
        if (cnt_ff == 16'h0) begin
          nxt_state  = S_IDLE;
          // rl7: set once, only RESET_N_IN clears it
          nxt_otp    = 1'b1;
          nxt_status = `ST_READY;
        end else begin
          nxt_cnt = cnt_ff - 16'h1;
        end
      end
      default: nxt_state = S_IDLE;
    endcase

    // rl21: powerdown clears status and aborts a pending sequence
    if (!RESET_POWERDOWN_N_IN) begin
      nxt_status = `ST_RESET;
      if (state_ff == S_ARMED) nxt_state = S_IDLE;
    end
  end

  // ==================================================
  // registers
  // rl2 rl6: protection pattern resets to all protected
  // otp_ff stands in for nonvolatile storage; a real part keeps it in array cells
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_ff     <= S_IDLE;
      prot_ff      <= '1;
      status_ff    <= `ST_READY;
      otp_ff       <= 1'b0;
      cfg_ff       <= 2'h0;
      cnt_ff       <= 16'h0;
      rdata_ff     <= 32'h0;
      wait_ff      <= 1'b1;
      ansv_ff      <= 1'b0;
      ans_ff       <= '0;
      susp_seen_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      prot_ff      <= nxt_prot;
      status_ff    <= nxt_status;
      otp_ff       <= nxt_otp;
      cfg_ff       <= nxt_cfg;
      cnt_ff       <= nxt_cnt;
      rdata_ff     <= nxt_rdata;
      wait_ff      <= nxt_wait;
      ansv_ff      <= nxt_ansv;
      ans_ff       <= nxt_ans;
      susp_seen_ff <= nxt_susp_seen;
    end
  end

  logic burst_clr_ff;
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) burst_clr_ff <= 1'b1;
    else burst_clr_ff <= !RESET_POWERDOWN_N_IN;
  end

  assign AVS_READDATA_OUT    = rdata_ff;
  assign AVS_WAITREQUEST_OUT = wait_ff;
  assign ANS_VALID_OUT       = ansv_ff;
  assign ANS_OUT             = ans_ff;
  assign LOCK_BUSY_OUT       = (state_ff == S_LOCK);
  assign LOCK_ACTIVE_OUT     = otp_ff;
  assign BURST_CFG_CLR_OUT   = burst_clr_ff;

  // ==================================================
  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  logic lock_ok;
  assign lock_ok = state_ff == S_ARMED && REQ_VALID_IN &&
                   REQ_IN.kind == flash_protect_pkg::OP_LOCK2 &&
                   REQ_IN.addr == `LOCK_ADDR2 && REQ_IN.data == `LOCK_DATA2 &&
                   RESET_POWERDOWN_N_IN && PROG_ERASE_PERMIT_IN;

  sequence lock_start;
    lock_ok;
  endsequence

  AST_LOCK_STICKY: assert property (otp_ff |=> otp_ff) // RL7
    else $error("permanent lock cleared");
  AST_LOCK_BUSY: assert property (lock_start |=> state_ff == S_LOCK && status_ff == 8'h00) // RL12
    else $error("lock did not start");
  AST_BAD_SEQ: assert property (state_ff == S_ARMED && REQ_VALID_IN && !lock_ok &&
      RESET_POWERDOWN_N_IN |=> status_ff == 8'hb1 && !otp_ff && state_ff == S_IDLE) // RL14
    else $error("bad sequence not flagged");
  AST_PERMIT: assert property (state_ff == S_IDLE && REQ_VALID_IN && !PROG_ERASE_PERMIT_IN
      |=> ANS_VALID_OUT && !ANS_OUT.accepted) // RL5
    else $error("op accepted without permit");
  AST_POWERDOWN: assert property (!RESET_POWERDOWN_N_IN |=> !(ANS_VALID_OUT &&
      ANS_OUT.accepted) && status_ff == 8'h00) // RL4
    else $error("op accepted in powerdown");
  AST_WP_PROT: assert property (state_ff == S_IDLE && REQ_VALID_IN && !WRITE_PROTECT_N_IN &&
      prot_ff[req_blk] && REQ_IN.kind inside {flash_protect_pkg::OP_PROGRAM,
      flash_protect_pkg::OP_ERASE} |=> !ANS_OUT.accepted && status_ff != 8'h80) // RL3
    else $error("protected block accepted");
  AST_OTP_PROG: assert property (state_ff == S_IDLE && REQ_VALID_IN && otp_ff &&
      RESET_POWERDOWN_N_IN &&
      in_otp(req_blk, cfg_ff[0], cfg_ff[1]) && REQ_IN.kind == flash_protect_pkg::OP_PROGRAM
      |=> status_ff == 8'h93 && !ANS_OUT.accepted) // RL13
    else $error("locked program not refused");
  AST_SUSPEND: assert property (LOCK_BUSY_OUT && cnt_ff != 16'h0 && SUSPEND_IN
      |=> LOCK_BUSY_OUT) // RL16
    else $error("lock suspended");
  AST_BUS_ANS: assert property (cpu_acc |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
    else $error("bus answer timing");

endmodule

// File: tb/cmd_host_model.sv
`timescale 1ns/1ps
// ====================
// host issuing program, erase and lock cycles
module cmd_host_model (
  input  wire logic                          clk_in,
  input  wire logic                          ans_valid_in,
  input  wire flash_protect_pkg::flash_ans_t ans_in,
  output logic                               req_valid_out,
  output flash_protect_pkg::flash_req_t      req_out
);
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end
  task automatic send(input flash_protect_pkg::op_kind_t k, input logic [19:0] a,
                      input logic [31:0] d, input bit wait_ans,
                      output flash_protect_pkg::flash_ans_t ans, output bit ok);
    ok = !wait_ans;
    ans = '0;
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_out <= '{kind: k, addr: a, data: d};
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    // released fields show the inverse, never a stale request
    req_out <= ~req_out;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk_in);
      if (ans_valid_in === 1'b1) begin
        ans = ans_in;
        ok = 1'b1;
      end
    end
  endtask
endmodule

// File: tb/flash_block_protect_lock_test.sv
`timescale 1ns/1ps
module flash_block_protect_lock_test;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, pdn_n = 1, permit = 1, wp_n = 0, susp = 0;
  logic [3:0] addr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic waitreq, req_valid, ans_valid, busy, active, burst_clr;
  flash_protect_pkg::flash_req_t req;
  flash_protect_pkg::flash_ans_t ans, got;
  int err_total = 0, check_count = 0;
  bit ok;
  logic [1:0] mc [11] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  logic [19:0] ma [11] = '{20'hff000, 20'hf8000, 20'hf87ff, 20'hf7fff, 20'h03fff,
                           20'h00fff, 20'h047ff, 20'hfc000, 20'h7c000, 20'h7ffff, 20'h78000};
  logic [6:0] mb [11] = '{7'h49, 7'h3e, 7'h3e, 7'h3d, 7'h00, 7'h00, 7'h04, 7'h49,
                          7'h1f, 7'h26, 7'h1e};

  initial forever #25 clk = ~clk;

  flash_block_protect_lock #(.LOCK_CYCLES(8)) i_dut (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(waitreq), .RESET_POWERDOWN_N_IN(pdn_n),
    .PROG_ERASE_PERMIT_IN(permit), .WRITE_PROTECT_N_IN(wp_n), .SUSPEND_IN(susp),
    .REQ_VALID_IN(req_valid), .REQ_IN(req), .ANS_VALID_OUT(ans_valid), .ANS_OUT(ans),
    .LOCK_BUSY_OUT(busy), .LOCK_ACTIVE_OUT(active), .BURST_CFG_CLR_OUT(burst_clr));

  cmd_host_model i_host (.clk_in(clk), .ans_valid_in(ans_valid), .ans_in(ans),
                         .req_valid_out(req_valid), .req_out(req));

  // ====================
  // report and compare
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic hang();
    err_total++;
    $display("FAIL wait expected answer seen none");
    end_sim();
  endtask

  // ====================
  // avalon master and command helpers
  task automatic av(input bit w, input logic [3:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge clk);
      if (waitreq === 1'b0) begin
        q = rdata;
        done = 1;
      end
    end
    wr <= 1'b0;
    rd <= 1'b0;
    if (!done) hang();
  endtask
  // status only compared on refusal; an accepted request leaves it open
  task automatic op(input flash_protect_pkg::op_kind_t k, input logic [19:0] a,
                    input logic acc, input logic [7:0] st);
    i_host.send(k, a, 32'h0, 1'b1, got, ok);
    if (!ok) hang();
    cmp("accepted", got.accepted, acc);
    if (!acc) begin
      av(0, `REG_STATUS_OFF, 0);
      cmp("status", q[7:0], st);
    end
  endtask
  task automatic lock(input logic [19:0] a2);
    i_host.send(flash_protect_pkg::OP_LOCK1, `LOCK_ADDR1, `LOCK_DATA1, 1'b0, got, ok);
    i_host.send(flash_protect_pkg::OP_LOCK2, a2, `LOCK_DATA2, 1'b0, got, ok);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    av(0, `REG_STATUS_OFF, 0);
    cmp("status reset", q[7:0], `ST_READY);
    av(0, 4'h6, 0);
    cmp("unmapped", q, 0);
    av(1, `REG_CTRL_OFF, 32'h2);
    op(flash_protect_pkg::OP_PROGRAM, 20'h05000, 0, `ST_PROG_LOCKED);
    $display("test reset done");
    av(1, `REG_STATUS_OFF, 0);
    av(1, `REG_PROT_OFF, 32'h6);
    op(flash_protect_pkg::OP_PROGRAM, 20'h05000, 1, 0);
    cmp("block", got.block, 7'h06);
    op(flash_protect_pkg::OP_ERASE, 20'h05800, 0, `ST_ERASE_LOCKED);
    av(1, `REG_STATUS_OFF, 0);
    av(1, `REG_PROT_OFF, 32'h8000_0006);
    op(flash_protect_pkg::OP_PROGRAM, 20'h05000, 0, `ST_PROG_LOCKED);
    wp_n <= 1'b1;
    op(flash_protect_pkg::OP_PROGRAM, 20'h05000, 1, 0);
    permit <= 1'b0;
    op(flash_protect_pkg::OP_ERASE, 20'h05000, 0, `ST_PERMIT_ERR);
    permit <= 1'b1;
    pdn_n <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("burst clear", burst_clr, 1);
    op(flash_protect_pkg::OP_PROGRAM, 20'h05000, 0, 8'h00);
    pdn_n <= 1'b1;
    av(1, `REG_STATUS_OFF, 0);
    $display("test pins done");
    for (int i = 0; i < 11; i++) begin
      av(1, `REG_CTRL_OFF, {30'h0, mc[i]});
      op(flash_protect_pkg::OP_ERASE, ma[i], 1, 0);
      cmp("map block", got.block, mb[i]);
    end
    $display("test map done");
    av(1, `REG_CTRL_OFF, 32'h2);
    lock(20'h00013);
    av(0, `REG_STATUS_OFF, 0);
    cmp("bad seq", q[7:0], `ST_BAD_SEQ);
    cmp("lock off", active, 0);
    av(1, `REG_STATUS_OFF, 0);
    lock(`LOCK_ADDR2);
    susp <= 1'b1;
    @(posedge clk);
    cmp("busy", busy, 1);
    ok = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      av(0, `REG_STATUS_OFF, 0);
      ok = (q[7:0] === `ST_READY);
    end
    if (!ok) hang();
    susp <= 1'b0;
    cmp("lock on", active, 1);
    op(flash_protect_pkg::OP_PROGRAM, 20'h01000, 0, `ST_PROG_LOCKED);
    av(1, `REG_STATUS_OFF, 0);
    op(flash_protect_pkg::OP_ERASE, 20'h01fff, 0, `ST_ERASE_LOCKED);
    op(flash_protect_pkg::OP_PROGRAM, 20'h02000, 1, 0);
    $display("test lock done");
    end_sim();
  end
endmodule
